// *** verilog/macc_pkg.sv ***
// Constants, types and register map of the math accelerator
//
// Overview of operation
// (RULE_01) Operation chosen by operand access order only
// (RULE_02) 32/16 divide: 32b quotient, 36 clocks
// (RULE_03) 16/16 divide: 16b quotient, 24 clocks
// (RULE_04) Multiply: B lsb,msb, A lsb,msb, read A
// (RULE_05) Divide: dividend into A, divisor into B
// (RULE_06) Two-byte dividend forms shorter divide sequence
// (RULE_07) Quotient from A msb first, remainder from B
// (RULE_08) Shift: four A bytes, control write, 36 clocks
// (RULE_09) Normalize: zero count, read mantissa and exponent
// (RULE_10) Busy flag set while running, cleared after
// (RULE_11) Unrelated register accesses leave sequence undisturbed
// (RULE_12) Out-of-order access corrupts; clearing busy restarts
// (RULE_13) Multiply and divide results added into accumulator
// (RULE_14) Accumulator reachable only while its flag clear
// (RULE_15) Five accumulator writes load it lsb first
// (RULE_16) Five accumulator reads return it msb first
// (RULE_17) Busy set on final operand byte; results held
// (RULE_18) Shift count and direction from control fields
package macc_pkg;
  localparam logic [7:0] ADDR_SHIFT_CTRL = 8'hd1;
  localparam logic [7:0] ADDR_CTRL_STATUS = 8'hd2;
  localparam logic [7:0] ADDR_PORT_A = 8'hd3;
  localparam logic [7:0] ADDR_PORT_B = 8'hd4;
  localparam logic [7:0] ADDR_ACC = 8'hd5;
  localparam int BUSY_BIT = 7;
  localparam int ACC_FLAG_BIT = 6;
  localparam int DIR_BIT = 0;
  localparam int CNT_W = 5;
  localparam logic [5:0] CYC_DIV32 = 6'h24;
  localparam logic [5:0] CYC_DIV16 = 6'h18;
  localparam logic [5:0] CYC_MUL = 6'h18;
  localparam logic [5:0] CYC_SHNORM = 6'h24;
  localparam logic [5:0] ITER_DIV32 = 6'h20;
  localparam logic [5:0] ITER_DIV16 = 6'h10;
  localparam logic [4:0] EXP_MAX = 5'h1f;
  localparam logic [2:0] ACC_LSB_IDX = 3'h0;
  localparam logic [2:0] ACC_MSB_IDX = 3'h4;
  localparam logic [1:0] PTR_MSB32 = 2'h3;
  localparam logic [1:0] PTR_MSB16 = 2'h1;
  typedef enum logic [3:0] {
    OP_MUL = 4'h1,
    OP_DIV32 = 4'h2,
    OP_DIV16 = 4'h4,
    OP_SHNORM = 4'h8
  } macc_op_t;
  typedef enum logic [12:0] {
    ST_IDLE = 13'h0001,
    ST_A1 = 13'h0002,
    ST_A2 = 13'h0004,
    ST_A3 = 13'h0008,
    ST_A4 = 13'h0010,
    ST_DB1 = 13'h0020,
    ST_MB1 = 13'h0040,
    ST_MB2 = 13'h0080,
    ST_MA1 = 13'h0100,
    ST_RUN = 13'h0200,
    ST_RDA = 13'h0400,
    ST_RDB = 13'h0800,
    ST_ERR = 13'h1000
  } macc_state_t;
endpackage

// *** verilog/macc_div.sv ***
// Iterative restoring divider, one quotient bit per clock
`timescale 1ns/10ps
module macc_div (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic start_in,
  input wire logic short_in,
  input wire logic [31:0] dividend_in,
  input wire logic [15:0] divisor_in,
  output logic [31:0] quot_out,
  output logic [15:0] rem_out
);
  logic [31:0] quo_q, quo_d;
  logic [15:0] rem_q, rem_d, dsr_q, dsr_d;
  logic [5:0] cnt_q, cnt_d;
  logic [16:0] trial, diff;

  always_comb begin
    quo_d = quo_q;
    rem_d = rem_q;
    dsr_d = dsr_q;
    cnt_d = cnt_q;
    trial = {rem_q, quo_q[31]};
    diff = trial - {1'b0, dsr_q};
    if (start_in) begin
      // Short dividend is pre-shifted so both sizes share one datapath
      quo_d = short_in ? {dividend_in[15:0], 16'h0000} : dividend_in; // RULE_06
      rem_d = 16'h0000;
      dsr_d = divisor_in;
      cnt_d = short_in ? macc_pkg::ITER_DIV16 : macc_pkg::ITER_DIV32;
    end else if (cnt_q != 6'h00) begin
      // Zero divisor gives no trap; 16/16 quotient is all ones, 32/16 low half is the inverted dividend msbs
      rem_d = diff[16] ? trial[15:0] : diff[15:0];
      quo_d = {quo_q[30:0], ~diff[16]};
      cnt_d = cnt_q - 6'h01;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      quo_q <= 32'h00000000;
      rem_q <= 16'h0000;
      dsr_q <= 16'h0000;
      cnt_q <= 6'h00;
    end else begin
      quo_q <= quo_d;
      rem_q <= rem_d;
      dsr_q <= dsr_d;
      cnt_q <= cnt_d;
    end
  end

  assign quot_out = quo_q;
  assign rem_out = rem_q;
endmodule

// *** verilog/macc_shn.sv ***
// Barrel shift and iterative normalize unit
`timescale 1ns/10ps
module macc_shn (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic start_in,
  input wire logic norm_in,
  input wire logic left_in,
  input wire logic [4:0] count_in,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic [4:0] exp_out
);
  logic [31:0] val_q, val_d;
  logic [4:0] exp_q, exp_d;
  logic act_q, act_d;

  always_comb begin
    val_d = val_q;
    exp_d = exp_q;
    act_d = act_q;
    if (start_in) begin
      exp_d = 5'h00;
      act_d = norm_in;
      if (norm_in) begin
        val_d = data_in;
      end else begin
        val_d = left_in ? (data_in << count_in) : (data_in >> count_in); // RULE_18
      end
    end else if (act_q) begin
      // Zero input stops at the largest exponent
      if (val_q[31] || exp_q == macc_pkg::EXP_MAX) begin // RULE_09
        act_d = 1'b0;
      end else begin
        val_d = {val_q[30:0], 1'b0};
        exp_d = exp_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      val_q <= 32'h00000000;
      exp_q <= 5'h00;
      act_q <= 1'b0;
    end else begin
      val_q <= val_d;
      exp_q <= exp_d;
      act_q <= act_d;
    end
  end

  assign data_out = val_q;
  assign exp_out = exp_q;
endmodule

// *** verilog/macc_top.sv ***
// Math accelerator with 40-bit accumulator on the special register port
`timescale 1ns/10ps
module macc_top (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out
);
  macc_pkg::macc_state_t state_q, state_d;
  macc_pkg::macc_op_t op_q, op_d;
  logic [31:0] opa_q, opa_d, res_q, res_d;
  logic [15:0] opb_q, opb_d, rem_q, rem_d;
  logic [39:0] acc_q, acc_d;
  logic [4:0] shcnt_q, shcnt_d;
  logic dir_q, dir_d;
  logic [5:0] cyc_q, cyc_d;
  logic [1:0] ptr_q, ptr_d;
  logic [2:0] widx_q, widx_d, ridx_q, ridx_d;
  logic [7:0] rdata_q, rdata_d;
  logic wr_a, wr_b, rd_a, rd_b, wr_acc, rd_acc, wr_sh, wr_ctl;
  logic busy, acc_flag, start, loading, clear;
  logic [31:0] div_q, shn_data;
  logic [15:0] div_r;
  logic [4:0] shn_exp;
  logic [31:0] product;

  assign wr_a = sfr_wr_in && sfr_addr_in == macc_pkg::ADDR_PORT_A;
  assign wr_b = sfr_wr_in && sfr_addr_in == macc_pkg::ADDR_PORT_B;
  assign rd_a = sfr_rd_in && sfr_addr_in == macc_pkg::ADDR_PORT_A;
  assign rd_b = sfr_rd_in && sfr_addr_in == macc_pkg::ADDR_PORT_B;
  assign wr_acc = sfr_wr_in && sfr_addr_in == macc_pkg::ADDR_ACC;
  assign rd_acc = sfr_rd_in && sfr_addr_in == macc_pkg::ADDR_ACC;
  assign wr_sh = sfr_wr_in && sfr_addr_in == macc_pkg::ADDR_SHIFT_CTRL;
  assign wr_ctl = sfr_wr_in && sfr_addr_in == macc_pkg::ADDR_CTRL_STATUS;
  assign clear = wr_ctl && !sfr_wdata_in[macc_pkg::BUSY_BIT];
  assign busy = state_q == macc_pkg::ST_RUN || state_q == macc_pkg::ST_ERR; // RULE_10
  assign acc_flag = state_q == macc_pkg::ST_RUN && op_q != macc_pkg::OP_SHNORM;
  assign loading = state_q inside {macc_pkg::ST_A1, macc_pkg::ST_A2, macc_pkg::ST_A3,
    macc_pkg::ST_A4, macc_pkg::ST_DB1, macc_pkg::ST_MB1, macc_pkg::ST_MB2, macc_pkg::ST_MA1};
  assign start = state_d == macc_pkg::ST_RUN && state_q != macc_pkg::ST_RUN;
  assign product = opa_q[15:0] * opb_q;

  macc_div u_div (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .start_in(start && op_d != macc_pkg::OP_MUL && op_d != macc_pkg::OP_SHNORM),
    .short_in(op_d == macc_pkg::OP_DIV16),
    .dividend_in(opa_d),
    .divisor_in(opb_d),
    .quot_out(div_q),
    .rem_out(div_r)
  );

  macc_shn u_shn (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .start_in(start && op_d == macc_pkg::OP_SHNORM),
    .norm_in(shcnt_d == 5'h00),
    .left_in(dir_q),
    .count_in(shcnt_d),
    .data_in(opa_d),
    .data_out(shn_data),
    .exp_out(shn_exp)
  );

  // Sequencer: the operation follows from the access order alone
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    opa_d = opa_q;
    opb_d = opb_q;
    cyc_d = cyc_q;
    ptr_d = ptr_q;
    res_d = res_q;
    rem_d = rem_q;
    acc_d = acc_q;
    shcnt_d = shcnt_q;
    dir_d = dir_q;
    widx_d = widx_q;
    ridx_d = ridx_q;
    if (wr_sh) begin
      shcnt_d = sfr_wdata_in[macc_pkg::CNT_W-1:0]; // RULE_18
    end
    if (wr_ctl) begin
      dir_d = sfr_wdata_in[macc_pkg::DIR_BIT];
    end
    unique case (state_q)
      macc_pkg::ST_IDLE, macc_pkg::ST_RDA, macc_pkg::ST_RDB: begin
        if (wr_a) begin // RULE_01
          opa_d[7:0] = sfr_wdata_in;
          state_d = macc_pkg::ST_A1;
        end else if (wr_b) begin
          opb_d[7:0] = sfr_wdata_in; // RULE_04
          state_d = macc_pkg::ST_MB1;
        end else if (state_q == macc_pkg::ST_RDA && rd_a) begin
          ptr_d = ptr_q - 2'h1; // RULE_07
          if (ptr_q == 2'h0) begin
            state_d = op_q == macc_pkg::OP_DIV32 || op_q == macc_pkg::OP_DIV16 ?
              macc_pkg::ST_RDB : macc_pkg::ST_IDLE;
            ptr_d = macc_pkg::PTR_MSB16;
          end
        end else if (state_q == macc_pkg::ST_RDB && rd_b) begin
          ptr_d = ptr_q - 2'h1; // RULE_07
          if (ptr_q == 2'h0) begin
            state_d = macc_pkg::ST_IDLE;
          end
        end else if ((state_q == macc_pkg::ST_RDA && rd_b) ||
                     (state_q == macc_pkg::ST_RDB && rd_a)) begin
          state_d = macc_pkg::ST_ERR; // RULE_12
        end
      end
      macc_pkg::ST_A1: begin
        // Only port strobes are decoded here, other addresses pass by
        if (wr_a) begin // RULE_11
          opa_d[15:8] = sfr_wdata_in; // RULE_05
          state_d = macc_pkg::ST_A2;
        end else if (wr_b || rd_a || rd_b) begin
          state_d = macc_pkg::ST_ERR;
        end
      end
      macc_pkg::ST_A2: begin
        if (wr_a) begin
          opa_d[23:16] = sfr_wdata_in;
          state_d = macc_pkg::ST_A3;
        end else if (wr_b) begin
          opa_d[31:16] = 16'h0000; // RULE_06
          opb_d[7:0] = sfr_wdata_in;
          op_d = macc_pkg::OP_DIV16;
          state_d = macc_pkg::ST_DB1;
        end else if (rd_a || rd_b) begin
          state_d = macc_pkg::ST_ERR;
        end
      end
      macc_pkg::ST_A3: begin
        if (wr_a) begin
          opa_d[31:24] = sfr_wdata_in;
          state_d = macc_pkg::ST_A4;
        end else if (wr_b || rd_a || rd_b) begin
          state_d = macc_pkg::ST_ERR;
        end
      end
      macc_pkg::ST_A4: begin
        if (wr_b) begin
          opb_d[7:0] = sfr_wdata_in; // RULE_05
          op_d = macc_pkg::OP_DIV32;
          state_d = macc_pkg::ST_DB1;
        end else if (wr_sh) begin
          op_d = macc_pkg::OP_SHNORM; // RULE_08
          cyc_d = macc_pkg::CYC_SHNORM;
          state_d = macc_pkg::ST_RUN;
        end else if (wr_a || rd_a || rd_b) begin
          state_d = macc_pkg::ST_ERR;
        end
      end
      macc_pkg::ST_DB1: begin
        if (wr_b) begin
          opb_d[15:8] = sfr_wdata_in; // RULE_17
          cyc_d = op_q == macc_pkg::OP_DIV32 ? macc_pkg::CYC_DIV32 : macc_pkg::CYC_DIV16;
          state_d = macc_pkg::ST_RUN;
        end else if (wr_a || rd_a || rd_b) begin
          state_d = macc_pkg::ST_ERR;
        end
      end
      macc_pkg::ST_MB1: begin
        if (wr_b) begin
          opb_d[15:8] = sfr_wdata_in;
          state_d = macc_pkg::ST_MB2;
        end else if (wr_a || rd_a || rd_b) begin
          state_d = macc_pkg::ST_ERR;
        end
      end
      macc_pkg::ST_MB2: begin
        if (wr_a) begin
          opa_d = {24'h000000, sfr_wdata_in};
          state_d = macc_pkg::ST_MA1;
        end else if (wr_b || rd_a || rd_b) begin
          state_d = macc_pkg::ST_ERR;
        end
      end
      macc_pkg::ST_MA1: begin
        if (wr_a) begin
          opa_d[15:8] = sfr_wdata_in; // RULE_04
          op_d = macc_pkg::OP_MUL;
          cyc_d = macc_pkg::CYC_MUL;
          state_d = macc_pkg::ST_RUN;
        end else if (wr_b || rd_a || rd_b) begin
          state_d = macc_pkg::ST_ERR;
        end
      end
      macc_pkg::ST_RUN: begin
        cyc_d = cyc_q - 6'h01;
        if (cyc_q == 6'h01) begin
          state_d = macc_pkg::ST_RDA; // RULE_10
          ptr_d = op_q == macc_pkg::OP_DIV16 ? macc_pkg::PTR_MSB16 : macc_pkg::PTR_MSB32;
          rem_d = div_r;
          unique case (op_q)
            macc_pkg::OP_MUL: begin
              res_d = product;
              acc_d = acc_q + {8'h00, product}; // RULE_13
            end
            macc_pkg::OP_SHNORM: begin
              res_d = shn_data;
              if (shcnt_q == 5'h00) begin
                shcnt_d = shn_exp; // RULE_09
              end
            end
            default: begin
              res_d = div_q; // RULE_02 RULE_03
              acc_d = acc_q + {8'h00, div_q}; // RULE_13
            end
          endcase
        end
      end
      macc_pkg::ST_ERR: begin
      end
    endcase
    // Accumulator port, refused while its flag is set
    if (!acc_flag && (wr_acc || rd_acc)) begin // RULE_14
      if (loading) begin
        state_d = macc_pkg::ST_ERR; // RULE_12
      end else if (wr_acc) begin
        acc_d[{widx_q, 3'b000} +: 8] = sfr_wdata_in; // RULE_15
        widx_d = widx_q == macc_pkg::ACC_MSB_IDX ? macc_pkg::ACC_LSB_IDX : widx_q + 3'h1;
        ridx_d = macc_pkg::ACC_MSB_IDX;
      end else begin
        ridx_d = ridx_q == macc_pkg::ACC_LSB_IDX ? macc_pkg::ACC_MSB_IDX : ridx_q - 3'h1;
        widx_d = macc_pkg::ACC_LSB_IDX; // RULE_16
      end
    end
    if (clear) begin
      state_d = macc_pkg::ST_IDLE; // RULE_12
      widx_d = macc_pkg::ACC_LSB_IDX;
      ridx_d = macc_pkg::ACC_MSB_IDX;
    end
  end

  // Read data is registered, so results stay put until read
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd_in) begin
      rdata_d = 8'h00;
      unique case (sfr_addr_in)
        macc_pkg::ADDR_SHIFT_CTRL: rdata_d = {3'h0, shcnt_q}; // RULE_09
        macc_pkg::ADDR_CTRL_STATUS: begin
          rdata_d[macc_pkg::BUSY_BIT] = busy; // RULE_10
          rdata_d[macc_pkg::ACC_FLAG_BIT] = acc_flag; // RULE_14
          rdata_d[macc_pkg::DIR_BIT] = dir_q;
        end
        macc_pkg::ADDR_PORT_A: begin
          if (state_q == macc_pkg::ST_RDA) begin
            rdata_d = res_q[{ptr_q, 3'b000} +: 8]; // RULE_07 RULE_17
          end
        end
        macc_pkg::ADDR_PORT_B: begin
          if (state_q == macc_pkg::ST_RDB) begin
            rdata_d = rem_q[{ptr_q[0], 3'b000} +: 8];
          end
        end
        macc_pkg::ADDR_ACC: begin
          if (!acc_flag) begin
            rdata_d = acc_q[{ridx_q, 3'b000} +: 8]; // RULE_16
          end
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= macc_pkg::ST_IDLE;
      op_q <= macc_pkg::OP_MUL;
      opa_q <= 32'h00000000;
      opb_q <= 16'h0000;
      res_q <= 32'h00000000;
      rem_q <= 16'h0000;
      acc_q <= 40'h0000000000;
      shcnt_q <= 5'h00;
      dir_q <= 1'b0;
      cyc_q <= 6'h00;
      ptr_q <= 2'h0;
      widx_q <= macc_pkg::ACC_LSB_IDX;
      ridx_q <= macc_pkg::ACC_MSB_IDX;
      rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      opa_q <= opa_d;
      opb_q <= opb_d;
      res_q <= res_d;
      rem_q <= rem_d;
      acc_q <= acc_d;
      shcnt_q <= shcnt_d;
      dir_q <= dir_d;
      cyc_q <= cyc_d;
      ptr_q <= ptr_d;
      widx_q <= widx_d;
      ridx_q <= ridx_d;
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata_out = rdata_q;

  // Helper: cycles spent in the run state
  logic [8:0] run_cnt_q;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_cnt_q <= 9'h000;
    end else begin
      run_cnt_q <= state_q == macc_pkg::ST_RUN ? run_cnt_q + 9'h001 : 9'h000;
    end
  end
  // Nonzero run count in the result phase means the run ended last cycle
  logic done;
  assign done = state_q == macc_pkg::ST_RDA && run_cnt_q != 9'h000;

  property p_div32_time;
    @(posedge clk_in) disable iff (!reset_n_in)
    done && op_q == macc_pkg::OP_DIV32 |-> run_cnt_q == 9'h024;
  endproperty
  a_div32_time: assert property (p_div32_time) else $error("div32 time wrong"); // RULE_02
  property p_div16_time;
    @(posedge clk_in) disable iff (!reset_n_in)
    done && op_q == macc_pkg::OP_DIV16 |-> run_cnt_q == 9'h018;
  endproperty
  a_div16_time: assert property (p_div16_time) else $error("div16 time wrong"); // RULE_03
  property p_mul_result;
    @(posedge clk_in) disable iff (!reset_n_in)
    done && op_q == macc_pkg::OP_MUL |-> res_q == opa_q[15:0] * opb_q && run_cnt_q == 9'h018;
  endproperty
  a_mul_result: assert property (p_mul_result) else $error("product wrong"); // RULE_04
  property p_div_result;
    @(posedge clk_in) disable iff (!reset_n_in)
    done && op_q == macc_pkg::OP_DIV32 && opb_q != 16'h0000 |->
      {16'h0000, res_q} * {32'h00000000, opb_q} + {32'h00000000, rem_q} == {16'h0000, opa_q}
      && rem_q < opb_q;
  endproperty
  a_div_result: assert property (p_div_result) else $error("quotient wrong"); // RULE_05
  property p_accumulate;
    @(posedge clk_in) disable iff (!reset_n_in)
    done && op_q != macc_pkg::OP_SHNORM |-> acc_q == $past(acc_q) + {8'h00, res_q};
  endproperty
  a_accumulate: assert property (p_accumulate) else $error("accumulate missed"); // RULE_13
  property p_busy_set;
    @(posedge clk_in) disable iff (!reset_n_in)
    state_q == macc_pkg::ST_DB1 && wr_b |=> busy [*8];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not held"); // RULE_17
  property p_clear;
    @(posedge clk_in) disable iff (!reset_n_in)
    clear |=> state_q == macc_pkg::ST_IDLE && !busy;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not restart"); // RULE_12
  property p_ignore;
    @(posedge clk_in) disable iff (!reset_n_in)
    loading && (sfr_wr_in || sfr_rd_in) && !(wr_a || wr_b || rd_a || rd_b || wr_acc ||
      rd_acc || wr_ctl || (wr_sh && state_q == macc_pkg::ST_A4)) |=> $stable(state_q);
  endproperty
  a_ignore: assert property (p_ignore) else $error("unrelated access disturbed"); // RULE_11
  property p_acc_read;
    @(posedge clk_in) disable iff (!reset_n_in)
    rd_acc && !acc_flag && ridx_q == macc_pkg::ACC_MSB_IDX && !loading
      |=> sfr_rdata_out == $past(acc_q[39:32]);
  endproperty
  a_acc_read: assert property (p_acc_read) else $error("acc msb read wrong"); // RULE_16
endmodule

// *** verification/macc_cpu.sv ***
// Behavioural processor model driving the special register port
`timescale 1ns/10ps
module macc_cpu (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end

  // One strobe cycle per byte; released lines invert so stale values never look fresh
  task automatic acc_cyc(input logic [7:0] a, input logic w, input logic [7:0] d,
                         output logic [7:0] q);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= w;
    rd_out <= !w;
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
    #1 q = rdata_in;
  endtask

  // Poll status until idle, and accumulator flag too when asked
  task automatic poll(input bit acc, output int n);
    logic [7:0] s;
    n = 0;
    do begin
      acc_cyc(macc_pkg::ADDR_CTRL_STATUS, 1'b0, 8'h00, s);
      n++;
    end while ((s[macc_pkg::BUSY_BIT] !== 1'b0 ||
                (acc && s[macc_pkg::ACC_FLAG_BIT] !== 1'b0)) && n < 60);
  endtask
endmodule

// *** verification/test_macc.sv ***
// Self-checking bench of the math accelerator
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_macc;
  localparam logic [7:0] PA = macc_pkg::ADDR_PORT_A;
  localparam logic [7:0] PB = macc_pkg::ADDR_PORT_B;
  localparam logic [7:0] AC = macc_pkg::ADDR_ACC;
  localparam logic [7:0] SC = macc_pkg::ADDR_SHIFT_CTRL;
  localparam logic [7:0] CS = macc_pkg::ADDR_CTRL_STATUS;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  logic [39:0] acc_e;

  always #2 clk = ~clk;

  macc_cpu i_cpu (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
                  .rd_out(rd), .wdata_out(wdata));
  macc_top i_dut (.clk_in(clk), .reset_n_in(reset_n), .sfr_addr_in(addr), .sfr_wr_in(wr),
                  .sfr_rd_in(rd), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run needs a few hundred cycles; this only catches a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_cpu.acc_cyc(a, 1'b1, d, q);
  endtask

  task automatic rd_b(input logic [7:0] a, output logic [7:0] q);
    i_cpu.acc_cyc(a, 1'b0, 8'h00, q);
  endtask

  task automatic wr_n(input logic [7:0] a, input int n, input logic [31:0] v);
    for (int i = 0; i < n; i++) wr_b(a, v[8*i +: 8]);
  endtask

  task automatic rd_n(input logic [7:0] a, input int n, input logic [39:0] e, input string nm);
    logic [7:0] q;
    for (int i = n - 1; i >= 0; i--) begin
      rd_b(a, q);
      `CHK(nm, e[8*i +: 8], q)
    end
  endtask

  // Busy must be seen on the first poll and gone within lim polls
  task automatic wait_done(input int lim);
    int n;
    i_cpu.poll(1'b0, n);
    `CHK("busy_seen", 1'b1, n > 1)
    `CHK("busy_clear", 1'b1, n <= lim)
  endtask

  task automatic acc_check();
    int n;
    i_cpu.poll(1'b1, n);
    `CHK("acc_free", 1'b1, n < 60)
    rd_n(AC, 5, acc_e, "acc");
  endtask

  task automatic t_mul();
    logic [7:0] q;
    logic [31:0] p;
    int n;
    p = 32'(16'hfffe) * 32'(16'hfffd);
    i_cpu.poll(1'b1, n);
    wr_n(AC, 4, 32'hffff_fff0);
    wr_b(AC, 8'h01);
    acc_e = 40'h01_ffff_fff0 + 40'(p);
    wr_b(PB, 8'hfd);
    wr_b(8'h80, 8'h55);
    wr_b(PB, 8'hff);
    rd_b(SC, q);
    wr_n(PA, 2, 32'h0000_fffe);
    wait_done(14);
    rd_n(PA, 4, 40'(p), "product");
    acc_check();
    $display("test mul done");
  endtask

  task automatic t_div(input int w, input logic [31:0] num, input logic [15:0] den);
    logic [31:0] qe;
    qe = num / 32'(den);
    acc_e = acc_e + 40'(qe);
    wr_n(PA, w / 8, num);
    wr_n(PB, 2, 32'(den));
    wait_done(w == 32 ? 20 : 14);
    rd_n(PA, w / 8, 40'(qe), "quotient");
    rd_n(PB, 2, 40'(num % 32'(den)), "remainder");
    acc_check();
    $display("test div %0d done", w);
  endtask

  task automatic t_shift();
    logic [31:0] d;
    d = 32'h8421_f00f;
    for (int dir = 0; dir < 2; dir++) begin
      wr_b(CS, 8'(dir));
      wr_n(PA, 4, d);
      wr_b(SC, 8'h05);
      wait_done(20);
      rd_n(PA, 4, 40'(dir == 1 ? d << 5 : d >> 5), "shift");
    end
    $display("test shift done");
  endtask

  task automatic t_norm();
    wr_b(CS, 8'h00);
    wr_n(PA, 4, 32'h0000_3a00);
    wr_b(SC, 8'h00);
    wait_done(20);
    rd_n(PA, 4, 40'h00_e800_0000, "mantissa");
    rd_n(SC, 1, 40'h12, "exponent");
    $display("test norm done");
  endtask

  task automatic t_err();
    logic [7:0] q;
    wr_b(PA, 8'h11);
    wr_b(PB, 8'h22);
    rd_b(CS, q);
    `CHK("err_busy", 1'b1, q[macc_pkg::BUSY_BIT])
    wr_b(CS, 8'h00);
    rd_b(CS, q);
    `CHK("restart_busy", 1'b0, q[macc_pkg::BUSY_BIT])
    t_div(16, 32'h0000_0064, 16'h0007);
    $display("test err done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_mul();
    t_div(32, 32'h89ab_cdef, 16'h0123);
    t_div(16, 32'h0000_beef, 16'h0007);
    t_shift();
    t_norm();
    t_err();
    end_sim();
  end
endmodule
